// ---- adc_conversion_control.sv ----
// Purpose: Digital control of a 10-bit successive approximation converter
// Assumes: APB slave, zero wait states, sample data from the analog side
// Notes:   Analog front end and prescaler ratios are outside this block
`timescale 1ns/1ps

// What this block does
// R01 - Channel and reference selections reach the converter only while enabled.
// R02 - Software should disable the converter before entering sleep.
// R03 - A 10-bit result spans the high and low result registers.
// R04 - Result is right adjusted, or left adjusted when left adjust is set.
// R05 - Software reads low before high, unless left adjusted 8-bit suffices.
// R06 - Reading the low result blocks result updates until high is read.
// R07 - A conversion finishing while blocked leaves results untouched.
// R08 - Reading the high result re-enables result updates.
// R09 - Completion flag is set even when the result was discarded.
// R10 - Writing one to start begins a single conversion.
// R11 - Start stays set during a software conversion, cleared at completion.
// R12 - A channel change mid-conversion waits for the current conversion to end.
// R13 - Auto trigger enable allows hardware-triggered conversions.
// R14 - Trigger source select picks the signal that triggers conversions.
// R15 - A trigger rising edge resets the prescaler and starts a conversion.
// R16 - A trigger still high at completion does not restart a conversion.
// R17 - Trigger edges during a conversion are ignored, not queued.
// R18 - Event flags trigger conversions regardless of their interrupt enables.
// R19 - Software must clear a trigger flag to get the next edge.
// R20 - Completion flag as trigger source gives free-running conversions.
// R21 - Software starts the first free-running conversion with the start bit.
// R22 - Free running continues whether or not the flag is cleared.
// R23 - With auto trigger on, writing start still starts one conversion.
// R24 - Start bit reads one during any conversion, as a busy indication.
// R25 - Normal conversion takes 13 converter clocks, the first one 25.
// R26 - At completion write results, set flag, clear start when single.
// R27 - Prescaler runs while enabled and is held in reset otherwise.
// R28 - Trigger edges found by comparing with last cycle's registered value.
module adc_conversion_control #(
  parameter int unsigned ADDR_W       = 8,
  parameter int unsigned PRESCALE_DIV = adc_ctl_pkg::PRESCALE_DIV_DEFAULT
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic [7:0]        trig_sources_in,
  input  wire logic [9:0]        sample_data_in,
  output logic                   converter_enable_out,
  output logic      [4:0]        channel_out,
  output logic      [1:0]        reference_out,
  output logic                   conversion_busy_out,
  output logic                   complete_flag_out
);

  // Gray coded along idle -> wait -> convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11
  } conv_st_t;

  typedef struct packed {
    conv_st_t   st;
    logic [4:0] cnt;
    logic       first_done;
    logic       converter_enable_bit;
    logic       auto_trigger_enable;
    logic       conversion_complete_flag;
    logic [2:0] trigger_source_select;
    logic [7:0] sel_tmp;
    logic [7:0] sel_app;
    logic [9:0] res;
    logic       lock;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;

  conv_link_if link ();

  // APB phase decode
  logic       acc;
  logic       wr;
  logic       rd;
  logic       setup;
  logic [7:0] addr;
  logic       mapped;
  logic       done;
  logic       free_run;
  logic       trig_start;
  logic [4:0] len;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic       ladj;
  logic [9:0] res_now;

  assign addr   = 8'(paddr_in);
  assign acc    = psel_in & penable_in;
  assign wr     = acc & pwrite_in;
  assign rd     = acc & ~pwrite_in;
  assign setup  = psel_in & ~penable_in;
  assign mapped = (addr == adc_ctl_pkg::OFS_CTRL1) || (addr == adc_ctl_pkg::OFS_CTRL2) ||
                  (addr == adc_ctl_pkg::OFS_SEL) || (addr == adc_ctl_pkg::OFS_RES_LO) ||
                  (addr == adc_ctl_pkg::OFS_RES_HI);

  // First conversion after enable is the long one
  assign len = s_reg.first_done ? adc_ctl_pkg::CONV_CYCLES_NORMAL
                                : adc_ctl_pkg::CONV_CYCLES_FIRST; // R25
  assign done = (s_reg.st == ST_CONV) && link.tick && (s_reg.cnt == len - 5'h01); // R25
  assign free_run = s_reg.auto_trigger_enable &&
                    (s_reg.trigger_source_select == adc_ctl_pkg::TSEL_FREE_RUN); // R20
  // Edges only count while idle, so nothing is queued
  assign trig_start = s_reg.converter_enable_bit && s_reg.auto_trigger_enable &&
                      (s_reg.st == ST_IDLE) && link.rise; // R13 R15 R17

  // Format from what the pair holds after this edge, so a landing result is not split
  assign ladj    = s_reg.sel_tmp[adc_ctl_pkg::SEL_LADJ];
  assign res_now = (done && !s_reg.lock) ? sample_data_in : s_reg.res; // R06
  assign res_lo  = ladj ? {res_now[1:0], 6'h00} : res_now[7:0]; // R04
  assign res_hi  = ladj ? res_now[9:2] : {6'h00, res_now[9:8]}; // R03 R04

  // Hooks to prescaler and edge detector
  assign link.enable   = s_reg.converter_enable_bit; // R27
  assign link.restart  = trig_start; // R15
  assign link.trig_sel = s_reg.trigger_source_select; // R14
  // Source 0 is our own flag; others are event flags set whatever their masks
  assign link.trig_vec = {trig_sources_in[7:1], s_reg.conversion_complete_flag}; // R18

  adc_prescaler #(
    .DIV (PRESCALE_DIV)
  ) u_prescaler (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .link   (link)
  );

  adc_trigger_edge u_trigger_edge (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .link   (link)
  );

  // Next-state: bus writes first, then the sequencer, so hardware set wins
  always_comb begin
    s_next = s_reg;

    // Register writes
    if (wr) begin
      case (addr)
        adc_ctl_pkg::OFS_CTRL1: begin
          s_next.converter_enable_bit = pwdata_in[adc_ctl_pkg::BIT_ENABLE];
          s_next.auto_trigger_enable  = pwdata_in[adc_ctl_pkg::BIT_AUTO];
          if (pwdata_in[adc_ctl_pkg::BIT_FLAG]) begin
            s_next.conversion_complete_flag = 1'b0;
          end
          if (pwdata_in[adc_ctl_pkg::BIT_START] && pwdata_in[adc_ctl_pkg::BIT_ENABLE] &&
              (s_reg.st == ST_IDLE)) begin
            s_next.st = ST_WAIT; // R10 R21 R23
          end
        end
        adc_ctl_pkg::OFS_CTRL2: begin
          s_next.trigger_source_select =
            pwdata_in[adc_ctl_pkg::TSEL_LSB +: adc_ctl_pkg::TSEL_W]; // R14
        end
        adc_ctl_pkg::OFS_SEL: begin
          s_next.sel_tmp = pwdata_in[7:0];
        end
        default: begin
        end
      endcase
    end

    // Lock from the low read's setup phase; data is captured there too
    if (setup && !pwrite_in && (addr == adc_ctl_pkg::OFS_RES_LO)) begin
      s_next.lock = 1'b1; // R06
    end
    if (rd && (addr == adc_ctl_pkg::OFS_RES_HI)) begin
      s_next.lock = 1'b0; // R08
    end

    // Read data is captured in the setup phase
    if (setup) begin
      case (addr)
        adc_ctl_pkg::OFS_CTRL1: begin
          s_next.rdata = {28'h0000000, s_reg.conversion_complete_flag, s_reg.auto_trigger_enable,
                          (s_reg.st != ST_IDLE), s_reg.converter_enable_bit}; // R24
        end
        adc_ctl_pkg::OFS_CTRL2:  s_next.rdata = {29'h00000000, s_reg.trigger_source_select};
        adc_ctl_pkg::OFS_SEL:    s_next.rdata = {24'h000000, s_reg.sel_tmp};
        adc_ctl_pkg::OFS_RES_LO: s_next.rdata = {24'h000000, res_lo};
        adc_ctl_pkg::OFS_RES_HI: s_next.rdata = {24'h000000, res_hi};
        default:                 s_next.rdata = 32'h00000000;
      endcase
    end

    // Sequencer
    case (s_reg.st)
      ST_IDLE: begin
        if (trig_start) begin
          s_next.st = ST_WAIT; // R15
        end
      end
      ST_WAIT: begin
        // Conversion begins on the next converter clock edge
        if (link.tick) begin
          s_next.st  = ST_CONV;
          s_next.cnt = 5'h00;
        end
      end
      ST_CONV: begin
        if (done) begin
          s_next.first_done               = 1'b1;
          s_next.conversion_complete_flag = 1'b1; // R09 R26
          if (!s_reg.lock) begin
            s_next.res = sample_data_in; // R03 R07 R26
          end
          if (free_run) begin
            s_next.st  = ST_CONV; // R20 R22
            s_next.cnt = 5'h00;
          end else begin
            s_next.st = ST_IDLE; // R11 R16 R26
          end
        end else if (link.tick) begin
          s_next.cnt = s_reg.cnt + 5'h01;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Selections follow the buffer only while idle or in the last converter clock
    if (s_reg.converter_enable_bit &&
        ((s_reg.st == ST_IDLE) || ((s_reg.st == ST_CONV) && (s_reg.cnt == len - 5'h01)))) begin
      s_next.sel_app = s_reg.sel_tmp; // R01 R12
    end

    // Disabling aborts and rearms the long first conversion
    if (!s_next.converter_enable_bit) begin
      s_next.st         = ST_IDLE;
      s_next.cnt        = 5'h00;
      s_next.first_done = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg                       <= '0;
      s_reg.st                    <= ST_IDLE;
      s_reg.sel_tmp               <= adc_ctl_pkg::SEL_RESET;
      s_reg.sel_app               <= adc_ctl_pkg::SEL_RESET;
      s_reg.trigger_source_select <= adc_ctl_pkg::TSEL_RESET;
      s_reg.res                   <= adc_ctl_pkg::RES_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs; zero wait state slave
  assign prdata_out           = s_reg.rdata;
  assign pready_out           = 1'b1;
  assign pslverr_out          = acc & ~mapped;
  assign converter_enable_out = s_reg.converter_enable_bit;
  assign channel_out   = s_reg.sel_app[adc_ctl_pkg::SEL_CH_LSB +: adc_ctl_pkg::SEL_CH_W];
  assign reference_out = s_reg.sel_app[adc_ctl_pkg::SEL_REF_LSB +: adc_ctl_pkg::SEL_REF_W];
  assign conversion_busy_out  = (s_reg.st != ST_IDLE); // R24
  assign complete_flag_out    = s_reg.conversion_complete_flag;

  property p_flag_on_done;
    @(posedge clk_in) disable iff (rst_in)
    done |=> s_reg.conversion_complete_flag;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) // R09
    else $error("flag not set at completion");

  property p_single_clears_start;
    @(posedge clk_in) disable iff (rst_in)
    (done && !free_run) |=> !conversion_busy_out;
  endproperty
  a_single_clears_start: assert property (p_single_clears_start) // R11
    else $error("start bit not cleared after single conversion");

  property p_free_run_continues;
    @(posedge clk_in) disable iff (rst_in)
    (done && free_run && !(wr && addr == adc_ctl_pkg::OFS_CTRL1)) |=> (s_reg.st == ST_CONV);
  endproperty
  a_free_run_continues: assert property (p_free_run_continues) // R20
    else $error("free running conversion stopped");

  property p_locked_result;
    @(posedge clk_in) disable iff (rst_in)
    (done && s_reg.lock) |=> $stable(s_reg.res);
  endproperty
  a_locked_result: assert property (p_locked_result) // R07
    else $error("blocked result was overwritten");

  property p_low_read_locks;
    @(posedge clk_in) disable iff (rst_in)
    (rd && addr == adc_ctl_pkg::OFS_RES_LO) |=> s_reg.lock;
  endproperty
  a_low_read_locks: assert property (p_low_read_locks) // R06
    else $error("low read did not block updates");

  property p_high_read_unlocks;
    @(posedge clk_in) disable iff (rst_in)
    (rd && addr == adc_ctl_pkg::OFS_RES_HI) |=> !s_reg.lock;
  endproperty
  a_high_read_unlocks: assert property (p_high_read_unlocks) // R08
    else $error("high read did not release updates");

  property p_edge_ignored_busy;
    @(posedge clk_in) disable iff (rst_in)
    ((s_reg.st == ST_CONV) && link.rise && !done) |=> (s_reg.st == ST_CONV);
  endproperty
  a_edge_ignored_busy: assert property (p_edge_ignored_busy) // R17
    else $error("trigger edge disturbed a running conversion");

  property p_sel_held_disabled;
    @(posedge clk_in) disable iff (rst_in)
    !s_reg.converter_enable_bit |=> $stable(s_reg.sel_app);
  endproperty
  a_sel_held_disabled: assert property (p_sel_held_disabled) // R01
    else $error("selection applied while disabled");

  property p_count_bound;
    @(posedge clk_in) disable iff (rst_in)
    (s_reg.st == ST_CONV) |-> (s_reg.cnt < len);
  endproperty
  a_count_bound: assert property (p_count_bound) // R25
    else $error("conversion ran past its length");

  property p_trigger_starts;
    @(posedge clk_in) disable iff (rst_in)
    trig_start |=> (s_reg.st == ST_WAIT) ##1 !link.tick;
  endproperty
  a_trigger_starts: assert property (p_trigger_starts) // R15
    else $error("trigger did not restart prescaler and start");
endmodule

// ---- adc_ctl_pkg.sv ----
// Purpose: Shared constants for the converter control block
// Assumes: APB register map with one 32-bit aligned word per register
// Notes:   Offsets are byte addresses; conversion counts are converter clocks, the prescale divide counts clk_in cycles
package adc_ctl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_SEL    = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_RES_HI = 8'h10;

  // First control register fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_START  = 1;
  localparam int BIT_AUTO   = 2;
  localparam int BIT_FLAG   = 3;

  // Second control register: trigger source select
  localparam int TSEL_LSB = 0;
  localparam int TSEL_W   = 3;
  localparam int TRIG_N   = 8;
  localparam logic [2:0] TSEL_FREE_RUN = 3'h0;

  // Channel / reference select register fields
  localparam int SEL_CH_LSB  = 0;
  localparam int SEL_CH_W    = 5;
  localparam int SEL_LADJ    = 5;
  localparam int SEL_REF_LSB = 6;
  localparam int SEL_REF_W   = 2;

  // Result and timing
  localparam int RESULT_W = 10;
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0D;
  localparam logic [4:0] CONV_CYCLES_FIRST  = 5'h19;
  localparam int PRESCALE_DIV_DEFAULT = 4;

  // Reset values
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [2:0] TSEL_RESET = 3'h0;
  localparam logic [9:0] RES_RESET  = 10'h000;

endpackage

// ---- conv_link_if.sv ----
// Purpose: Links the control core with its prescaler and trigger detector
// Assumes: All signals on clk_in
// Notes:   tick and rise are one-cycle pulses
`timescale 1ns/1ps
interface conv_link_if;
  logic       enable;
  logic       restart;
  logic       tick;
  logic [2:0] trig_sel;
  logic [7:0] trig_vec;
  logic       rise;

  modport ctl (output enable, output restart, output trig_sel, output trig_vec,
               input tick, input rise);
  modport pre (input enable, input restart, output tick);
  modport edg (input trig_sel, input trig_vec, output rise);
endinterface

// ---- adc_prescaler.sv ----
// Purpose: Converter clock prescaler producing a tick pulse
// Assumes: Synchronous active-high reset
// Notes:   Held cleared while disabled; restart realigns the phase
`timescale 1ns/1ps
module adc_prescaler #(
  parameter int unsigned DIV = adc_ctl_pkg::PRESCALE_DIV_DEFAULT
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  conv_link_if.pre  link
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } pre_state_t;

  pre_state_t s_reg;
  pre_state_t s_next;

  // Count only while enabled; a trigger restarts the divider
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (!link.enable || link.restart) begin // R27 R15
      s_next.cnt = '0;
    end else if (s_reg.cnt == LAST) begin
      s_next.cnt  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.tick = s_reg.tick;

  property p_no_tick_disabled;
    @(posedge clk_in) disable iff (rst_in)
    (!link.enable || link.restart) |=> !link.tick;
  endproperty
  a_no_tick_disabled: assert property (p_no_tick_disabled) // R27
    else $error("prescaler ticked while held");
endmodule

// ---- adc_trigger_edge.sv ----
// Purpose: Rising edge detector on the selected trigger source
// Assumes: Trigger sources come from logic on clk_in
// Notes:   Previous value is taken from the selected source only
`timescale 1ns/1ps
module adc_trigger_edge (
  input  wire logic clk_in,
  input  wire logic rst_in,
  conv_link_if.edg  link
);
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t s_reg;
  edge_state_t s_next;
  logic        cur;

  // Compare with last cycle's value; a held level gives no edge
  always_comb begin
    cur         = link.trig_vec[link.trig_sel];
    s_next      = s_reg;
    s_next.prev = cur; // R28
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.rise = cur & ~s_reg.prev; // R28 R16

  property p_rise_needs_low;
    @(posedge clk_in) disable iff (rst_in)
    link.rise |-> cur && !$past(cur);
  endproperty
  a_rise_needs_low: assert property (p_rise_needs_low) // R16
    else $error("edge reported on a held level");
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero wait APB slave; prescaler divide cut to 2 for speed
// Notes:   Samples come from an xorshift seeded with 45
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 2;
  logic        clk_in;
  logic        rst_in;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  trig;
  logic [9:0]  sample;
  logic        en_o;
  logic [4:0]  chan;
  logic [1:0]  refsel;
  logic        busy;
  logic        flag;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [9:0]  res_a;
  logic        err;
  int          error_cnt;
  int          n_checks;
  int          cyc;
  int          t;
  int          c0;

  adc_conversion_control #(.PRESCALE_DIV(DIV)) adc_conversion_control_i (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .trig_sources_in(trig), .sample_data_in(sample),
    .converter_enable_out(en_o), .channel_out(chan), .reference_out(refsel),
    .conversion_busy_out(busy), .complete_flag_out(flag));

  // Free clock, 10 ns period
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard; whole run needs well under this
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; result taken at the edge where pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Bounded wait on the busy output
  task automatic wait_busy(input logic v, input int lim);
    t = 0;
    while (busy !== v && t < lim) begin
      @(posedge clk_in);
      t++;
    end
    check("busy", {31'h0, busy}, {31'h0, v});
  endtask

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [31:0] exp_lo(logic [9:0] r, logic l);
    return l ? {24'h0, r[1:0], 6'h00} : {24'h0, r[7:0]};
  endfunction

  function automatic logic [31:0] exp_hi(logic [9:0] r, logic l);
    return l ? {24'h0, r[9:2]} : {22'h0, r[9:8]};
  endfunction

  // Low then high, as software must
  task automatic check_res(input logic [9:0] r, input logic l);
    apb(1'b0, adc_ctl_pkg::OFS_RES_LO, 32'h0);
    check("res_lo", rd, exp_lo(r, l));
    apb(1'b0, adc_ctl_pkg::OFS_RES_HI, 32'h0);
    check("res_hi", rd, exp_hi(r, l));
  endtask

  // New random sample, start, wait for completion, return length in c0
  task automatic convert(input logic [31:0] ctl);
    seed = xs(seed);
    sample <= seed[9:0];
    apb(1'b1, adc_ctl_pkg::OFS_CTRL1, ctl);
    c0 = cyc;
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 200);
    c0 = cyc - c0;
  endtask

  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trig = 8'h00;
    sample = 10'h000;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    seed = 32'h0000002D;
    rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values of every register, then an unmapped word
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      check("reset_val", rd, 32'h0);
    end
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    check("unmapped_err", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped_rd", rd, 32'h0);
    // Selections held back until the converter is enabled
    apb(1'b1, adc_ctl_pkg::OFS_SEL, 32'hC5);
    repeat (3) @(posedge clk_in);
    check("chan_off", {27'h0, chan}, 32'h0);
    apb(1'b1, adc_ctl_pkg::OFS_CTRL1, 32'h1);
    repeat (3) @(posedge clk_in);
    check("chan_on", {27'h0, chan}, 32'h5);
    check("ref_on", {30'h0, refsel}, 32'h3);
    // First conversion: busy bit, channel lock, 25 converter clocks
    seed = xs(seed);
    sample <= seed[9:0];
    apb(1'b1, adc_ctl_pkg::OFS_CTRL1, 32'hB);
    c0 = cyc;
    apb(1'b0, adc_ctl_pkg::OFS_CTRL1, 32'h0);
    check("start_busy", {31'h0, rd[1]}, 32'h1);
    apb(1'b1, adc_ctl_pkg::OFS_SEL, 32'h09);
    check("chan_locked", {27'h0, chan}, 32'h5);
    wait_busy(1'b0, 200);
    c0 = cyc - c0;
    check("len_first", 32'(c0 >= DIV * 25 && c0 <= DIV * 27 + 6), 32'h1);
    check("flag", {31'h0, flag}, 32'h1);
    check_res(sample, 1'b0);
    check("chan_new", {27'h0, chan}, 32'h9);
    apb(1'b0, adc_ctl_pkg::OFS_CTRL1, 32'h0);
    check("ctrl_done", {28'h0, rd[3:0]}, 32'h9);
    // Normal length, left adjusted read-out
    apb(1'b1, adc_ctl_pkg::OFS_SEL, 32'h29);
    convert(32'hB);
    check("len_norm", 32'(c0 >= DIV * 13 && c0 <= DIV * 15 + 6), 32'h1);
    check_res(sample, 1'b1);
    // Low read blocks updates; the lost result still sets the flag
    res_a = sample;
    apb(1'b0, adc_ctl_pkg::OFS_RES_LO, 32'h0);
    convert(32'hB);
    check("flag_lost", {31'h0, flag}, 32'h1);
    apb(1'b0, adc_ctl_pkg::OFS_RES_HI, 32'h0);
    check("hi_blocked", rd, exp_hi(res_a, 1'b1));
    check_res(res_a, 1'b1);
    convert(32'hB);
    check_res(sample, 1'b1);
    // Auto trigger off: an edge on the selected source starts nothing
    apb(1'b1, adc_ctl_pkg::OFS_CTRL2, 32'h1);
    trig <= 8'h02;
    repeat (4) @(posedge clk_in);
    check("trig_no_auto", {31'h0, busy}, 32'h0);
    trig <= 8'h00;
    // Each of trigger sources 1 to 7: others ignored, edge starts, no queue, no restart
    apb(1'b1, adc_ctl_pkg::OFS_SEL, 32'h00);
    for (int n = 1; n < 8; n++) begin
      apb(1'b1, adc_ctl_pkg::OFS_CTRL2, 32'(n));
      apb(1'b1, adc_ctl_pkg::OFS_CTRL1, 32'hD);
      @(posedge clk_in);
      trig <= ~(8'h01 << n) & 8'hFE;
      repeat (6) @(posedge clk_in);
      check("trig_other", {31'h0, busy}, 32'h0);
      trig <= 8'h00;
      @(posedge clk_in);
      trig <= 8'h01 << n;
      wait_busy(1'b1, 6);
      trig <= 8'h00;
      repeat (2) @(posedge clk_in);
      trig <= 8'h01 << n;
      wait_busy(1'b0, 200);
      repeat (DIV * 16) @(posedge clk_in);
      check("no_requeue", {31'h0, busy}, 32'h0);
      trig <= 8'h00;
    end
    // Start bit still works with auto trigger on
    convert(32'hF);
    check("auto_start", {31'h0, flag}, 32'h1);
    // Free running on the completion flag, flag cleared only by the starting write
    apb(1'b1, adc_ctl_pkg::OFS_CTRL2, 32'h0);
    apb(1'b1, adc_ctl_pkg::OFS_CTRL1, 32'hF);
    t = 0;
    while (flag !== 1'b1 && t < 200) begin
      @(posedge clk_in);
      t++;
    end
    seed = xs(seed);
    sample <= seed[9:0];
    repeat (DIV * 16 + 6) @(posedge clk_in);
    check("free_busy", {31'h0, busy}, 32'h1);
    check_res(sample, 1'b0);
    apb(1'b1, adc_ctl_pkg::OFS_CTRL1, 32'h0);
    repeat (2) @(posedge clk_in);
    check("off_busy", {31'h0, busy}, 32'h0);
    check("off_en", {31'h0, en_o}, 32'h0);
    close_out();
  end
endmodule
